/* File: rtl/isr_pkg.sv */
// Package: register map, field positions, reset values for status unit
package isr_pkg;
  // Register byte offsets
  localparam logic [7:0] ESR_OFS = 8'h00;
  localparam logic [7:0] ESE_OFS = 8'h04;
  localparam logic [7:0] SRE_OFS = 8'h08;
  localparam logic [7:0] STB_OFS = 8'h0c;
  localparam logic [7:0] CTRL_OFS = 8'h10;
  localparam logic [7:0] CMD_OFS = 8'h14;
  localparam logic [7:0] OPC_OFS = 8'h18;
  localparam logic [7:0] OPER_COND_OFS = 8'h20;
  localparam logic [7:0] OPER_EVT_OFS = 8'h24;
  localparam logic [7:0] OPER_EN_OFS = 8'h28;
  localparam logic [7:0] OPER_PTR_OFS = 8'h2c;
  localparam logic [7:0] OPER_NTR_OFS = 8'h30;
  localparam logic [7:0] QUES_COND_OFS = 8'h34;
  localparam logic [7:0] QUES_EVT_OFS = 8'h38;
  localparam logic [7:0] QUES_EN_OFS = 8'h3c;
  localparam logic [7:0] QUES_PTR_OFS = 8'h40;
  localparam logic [7:0] QUES_NTR_OFS = 8'h44;
  localparam logic [7:0] ERR_POP_OFS = 8'h48;
  localparam logic [7:0] ERR_CNT_OFS = 8'h4c;
  // Field positions
  localparam int ESR_OPC_BIT = 0;
  localparam int ESR_PON_BIT = 7;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_QUES_BIT = 3;
  localparam int STB_OPER_BIT = 7;
  localparam int STB_MAV_BIT = 4;
  localparam int STB_EAV_BIT = 2;
  localparam int OPER_INTEG_BIT = 3;
  localparam int QUES_OVF_BIT = 0;
  localparam int CTRL_PSC_BIT = 0;
  localparam int CTRL_TRACE_BIT = 1;
  localparam int CMD_CLS_BIT = 0;
  localparam int CMD_RST_BIT = 1;
  localparam int CMD_DCL_BIT = 2;
  localparam int CMD_OPC_BIT = 3;
  localparam int CMD_OPCQ_BIT = 4;
  // Reset values and error queue depth
  localparam logic [7:0] ESR_RST = 8'h80;
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam logic [15:0] PTR_RST = 16'h7fff;
  localparam logic [15:0] NTR_RST = 16'h0000;
  localparam int ERR_DEPTH = 255;
  // Empty-queue answer: code 0, text index 0 means "No error"
  localparam logic [15:0] NO_ERR_CODE = 16'h0000;
  localparam logic [7:0] NO_ERR_TEXT = 8'h00;
  // Error entry: signed code plus text table index
  typedef struct packed {
    logic [15:0] code;
    logic [7:0] text;
  } isr_err_type;
  // Output-queue word from the query machine
  typedef struct packed {
    logic valid;
    logic [7:0] value;
  } isr_oq_type;
  typedef enum logic [1:0] {
    ISR_OC_IDLE = 2'b00,
    ISR_OC_ACTIVE = 2'b01
  } isr_oc_type;
endpackage

/* File: rtl/isr_status.sv */
// Status reporting, OPC machines, error queue and panel trace
`timescale 1ns/100ps
module isr_status #(
  parameter int DEPTH = isr_pkg::ERR_DEPTH,
  parameter int AW = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic meas_busy,
  input wire logic integ_active,
  input wire logic integ_ovf,
  input wire logic err_push,
  input wire isr_pkg::isr_err_type err_in,
  input wire logic link_serial,
  input wire logic link_usb,
  input wire logic local_mode,
  input wire logic pm_keep_masks,
  input wire logic [7:0] pm_ese,
  input wire logic [7:0] pm_sre,
  output logic srq,
  output logic usb_intr_req,
  output isr_pkg::isr_oq_type oq_out,
  output logic trace_show,
  output isr_pkg::isr_err_type trace_err,
  output logic meters_blank
);
  // Bus address phase capture
  logic wr_q, rd_q;
  logic [7:0] addr_q;
  wire logic addr_ok = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q <= addr_ok & hwrite;
      rd_q <= addr_ok & ~hwrite;
      addr_q <= haddr[7:0];
    end
  end
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction
  // Write and read strobes in the data phase
  wire logic wr_ese = wr_q & hit(addr_q, isr_pkg::ESE_OFS);
  wire logic wr_sre = wr_q & hit(addr_q, isr_pkg::SRE_OFS);
  wire logic wr_ctrl = wr_q & hit(addr_q, isr_pkg::CTRL_OFS);
  wire logic wr_cmd = wr_q & hit(addr_q, isr_pkg::CMD_OFS);
  wire logic rd_esr = rd_q & hit(addr_q, isr_pkg::ESR_OFS);
  wire logic rd_oev = rd_q & hit(addr_q, isr_pkg::OPER_EVT_OFS);
  wire logic rd_qev = rd_q & hit(addr_q, isr_pkg::QUES_EVT_OFS);
  wire logic rd_err = rd_q & hit(addr_q, isr_pkg::ERR_POP_OFS);
  wire logic cls = wr_cmd & hwdata[isr_pkg::CMD_CLS_BIT];
  wire logic rst_cmd = wr_cmd & (hwdata[isr_pkg::CMD_RST_BIT] |
                                 hwdata[isr_pkg::CMD_DCL_BIT]);
  wire logic opc_cmd = wr_cmd & hwdata[isr_pkg::CMD_OPC_BIT];
  wire logic opcq_cmd = wr_cmd & hwdata[isr_pkg::CMD_OPCQ_BIT];

  // Control: power-on clear and trace enable
  logic [1:0] ctrl_q;
  logic [1:0] ctrl_d;
  assign ctrl_d = wr_ctrl ? hwdata[1:0] : ctrl_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ctrl_q <= isr_pkg::CTRL_RST;
    else ctrl_q <= ctrl_d;
  end
  // The clear-on-power bit is only stored here; the backup store outside
  // reads it and answers with pm_keep_masks at the next power-up
  wire logic trace_en = ctrl_q[isr_pkg::CTRL_TRACE_BIT];

  // Masks: loaded from backup one cycle after reset release when kept
  logic boot_q;
  logic [7:0] ese_q, sre_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) boot_q <= 1'b1;
    else boot_q <= 1'b0;
  end
  // Reset cannot load port values, so the restore is a clocked step
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ese_q <= 8'h00;
      sre_q <= 8'h00;
    end else if (boot_q) begin
      ese_q <= pm_keep_masks ? pm_ese : 8'h00;
      sre_q <= pm_keep_masks ? pm_sre : 8'h00;
    end else begin
      if (wr_ese) ese_q <= hwdata[7:0];
      if (wr_sre) sre_q <= hwdata[7:0];
    end
  end

  // OPC command and query machines
  isr_pkg::isr_oc_type oc_q, oq_q;
  wire logic pending = meas_busy;
  wire logic oc_done = (oc_q == isr_pkg::ISR_OC_ACTIVE) & ~pending;
  wire logic oq_done = (oq_q == isr_pkg::ISR_OC_ACTIVE) & ~pending;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oc_q <= isr_pkg::ISR_OC_IDLE;
      oq_q <= isr_pkg::ISR_OC_IDLE;
    end else if (rst_cmd) begin
      oc_q <= isr_pkg::ISR_OC_IDLE;
      oq_q <= isr_pkg::ISR_OC_IDLE;
    end else begin
      case (oc_q)
        isr_pkg::ISR_OC_IDLE:
          if (opc_cmd) oc_q <= isr_pkg::ISR_OC_ACTIVE;
        isr_pkg::ISR_OC_ACTIVE:
          if (~pending) oc_q <= isr_pkg::ISR_OC_IDLE;
        default: oc_q <= isr_pkg::ISR_OC_IDLE;
      endcase
      case (oq_q)
        isr_pkg::ISR_OC_IDLE:
          if (opcq_cmd) oq_q <= isr_pkg::ISR_OC_ACTIVE;
        isr_pkg::ISR_OC_ACTIVE:
          if (~pending) oq_q <= isr_pkg::ISR_OC_IDLE;
        default: oq_q <= isr_pkg::ISR_OC_IDLE;
      endcase
    end
  end
  // Query answer: value 1 held until the host reads the OPC word or a reset or device clear command drops it
  wire logic rd_opc = rd_q & hit(addr_q, isr_pkg::OPC_OFS);
  // A read clears only an answer it returned; one that lands between
  // the address and data edges waits for the next read
  wire logic opc_seen = hrdata[$bits(isr_pkg::isr_oq_type) - 1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) oq_out <= '0;
    else if (oq_done) oq_out <= '{valid: 1'b1, value: 8'h01};
    else if ((rd_opc & opc_seen) | rst_cmd) oq_out <= '0;
  end

  // Standard event status: set wins over read-clear
  logic [7:0] esr_q, esr_set;
  always_comb begin
    esr_set = 8'h00;
    esr_set[isr_pkg::ESR_OPC_BIT] = oc_done;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) esr_q <= isr_pkg::ESR_RST;
    else if (cls) esr_q <= esr_set;
    // Read clears only the bits it returned, so a late set survives
    else if (rd_esr) esr_q <= (esr_q & ~hrdata[7:0]) | esr_set;
    else esr_q <= esr_q | esr_set;
  end

  // SCPI register sets: operation and questionable
  logic [15:0] ocond_q, oevt_q, oen_q, optr_q, ontr_q;
  logic [15:0] qcond_q, qevt_q, qen_q, qptr_q, qntr_q;
  logic [15:0] ocond_d, qcond_d;
  always_comb begin
    ocond_d = 16'h0000;
    ocond_d[isr_pkg::OPER_INTEG_BIT] = integ_active;
    qcond_d = 16'h0000;
    qcond_d[isr_pkg::QUES_OVF_BIT] = integ_ovf;
  end
  function automatic logic [15:0] edges(input logic [15:0] o,
      input logic [15:0] n, input logic [15:0] p, input logic [15:0] f);
    return (p & n & ~o) | (f & o & ~n);
  endfunction
  wire logic [15:0] oset = edges(ocond_q, ocond_d, optr_q, ontr_q);
  wire logic [15:0] qset = edges(qcond_q, qcond_d, qptr_q, qntr_q);
  // Event reads clear only the bits that the read returned
  wire logic [15:0] oevt_keep = rd_oev ? ~hrdata[15:0] : 16'hffff;
  wire logic [15:0] qevt_keep = rd_qev ? ~hrdata[15:0] : 16'hffff;
  // Only enables and filters are written; cond and event are read-only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ocond_q <= 16'h0000;
      qcond_q <= 16'h0000;
      oevt_q <= 16'h0000;
      qevt_q <= 16'h0000;
      oen_q <= 16'h0000;
      qen_q <= 16'h0000;
      optr_q <= isr_pkg::PTR_RST;
      qptr_q <= isr_pkg::PTR_RST;
      ontr_q <= isr_pkg::NTR_RST;
      qntr_q <= isr_pkg::NTR_RST;
    end else begin
      ocond_q <= ocond_d;
      qcond_q <= qcond_d;
      oevt_q <= (cls ? 16'h0000 : oevt_q & oevt_keep) | oset;
      qevt_q <= (cls ? 16'h0000 : qevt_q & qevt_keep) | qset;
      if (wr_q & hit(addr_q, isr_pkg::OPER_EN_OFS))
        oen_q <= hwdata[15:0];
      if (wr_q & hit(addr_q, isr_pkg::OPER_PTR_OFS))
        optr_q <= hwdata[15:0];
      if (wr_q & hit(addr_q, isr_pkg::OPER_NTR_OFS))
        ontr_q <= hwdata[15:0];
      if (wr_q & hit(addr_q, isr_pkg::QUES_EN_OFS))
        qen_q <= hwdata[15:0];
      if (wr_q & hit(addr_q, isr_pkg::QUES_PTR_OFS))
        qptr_q <= hwdata[15:0];
      if (wr_q & hit(addr_q, isr_pkg::QUES_NTR_OFS))
        qntr_q <= hwdata[15:0];
    end
  end

  // Error queue: array with read/write pointers and count
  isr_pkg::isr_err_type mem [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  wire logic q_empty = (cnt_q == '0);
  wire logic q_full = (cnt_q == (AW+1)'(DEPTH));
  wire logic do_push = err_push & ~q_full & ~cls;
  // Queue state at the address edge: a read that answered No error
  // must not pop an entry pushed before its data edge
  logic pop_ok_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) pop_ok_q <= 1'b0;
    else pop_ok_q <= ~q_empty;
  end
  wire logic do_pop = rd_err & pop_ok_q & ~q_empty;
  function automatic logic [AW-1:0] wrap(input logic [AW-1:0] p);
    return (p == (AW)'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction
  always_ff @(posedge hclk) begin
    if (do_push) mem[wp_q] <= err_in;
  end
  // CLS drops everything; a push in the same cycle is dropped too
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (cls) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) wp_q <= wrap(wp_q);
      if (do_pop) rp_q <= wrap(rp_q);
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
  wire isr_pkg::isr_err_type head = mem[rp_q];
  wire isr_pkg::isr_err_type err_ans = q_empty ?
      isr_pkg::isr_err_type'{code: isr_pkg::NO_ERR_CODE,
                             text: isr_pkg::NO_ERR_TEXT} :
      head;

  // Status byte and service request
  wire logic esb = |(esr_q & ese_q);
  logic [7:0] stb;
  always_comb begin
    stb = 8'h00;
    stb[isr_pkg::STB_ESB_BIT] = esb;
    stb[isr_pkg::STB_QUES_BIT] = |(qevt_q & qen_q);
    stb[isr_pkg::STB_OPER_BIT] = |(oevt_q & oen_q);
    stb[isr_pkg::STB_EAV_BIT] = ~q_empty;
    stb[isr_pkg::STB_MAV_BIT] = oq_out.valid;
  end
  wire logic rqs = |(stb & sre_q) & ~link_serial;

  // Trace: oldest entry unless local, disabled, or empty
  wire logic show = trace_en & ~local_mode & ~q_empty;

  // Read mux; unmapped offsets read zero with OKAY
  logic [31:0] rdata_d;
  always_comb begin
    case (haddr[7:0])
      isr_pkg::ESR_OFS: rdata_d = {24'h0, esr_q};
      isr_pkg::ESE_OFS: rdata_d = {24'h0, ese_q};
      isr_pkg::SRE_OFS: rdata_d = {24'h0, sre_q};
      isr_pkg::STB_OFS: rdata_d = {24'h0, stb[7], rqs, stb[5:0]};
      isr_pkg::CTRL_OFS: rdata_d = {30'h0, ctrl_q};
      isr_pkg::OPC_OFS: rdata_d = {23'h0, oq_out};
      isr_pkg::OPER_COND_OFS: rdata_d = {16'h0, ocond_q};
      isr_pkg::OPER_EVT_OFS: rdata_d = {16'h0, oevt_q};
      isr_pkg::OPER_EN_OFS: rdata_d = {16'h0, oen_q};
      isr_pkg::OPER_PTR_OFS: rdata_d = {16'h0, optr_q};
      isr_pkg::OPER_NTR_OFS: rdata_d = {16'h0, ontr_q};
      isr_pkg::QUES_COND_OFS: rdata_d = {16'h0, qcond_q};
      isr_pkg::QUES_EVT_OFS: rdata_d = {16'h0, qevt_q};
      isr_pkg::QUES_EN_OFS: rdata_d = {16'h0, qen_q};
      isr_pkg::QUES_PTR_OFS: rdata_d = {16'h0, qptr_q};
      isr_pkg::QUES_NTR_OFS: rdata_d = {16'h0, qntr_q};
      isr_pkg::ERR_POP_OFS: rdata_d = {8'h0, err_ans};
      isr_pkg::ERR_CNT_OFS: rdata_d = {23'h0, cnt_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end
  // Read data registered at address phase: zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h0000_0000;
    else if (addr_ok & ~hwrite) hrdata <= rdata_d;
  end

  // Registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      srq <= 1'b0;
      usb_intr_req <= 1'b0;
      trace_show <= 1'b0;
      trace_err <= '0;
      meters_blank <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      srq <= rqs;
      usb_intr_req <= rqs & link_usb;
      trace_show <= show & ~cls;
      trace_err <= (show & ~cls) ? head : '0;
      meters_blank <= show & ~cls;
    end
  end
endmodule // isr_status

/* File: verif/isr_status_props.sv */
// Checker: port-level properties of the status unit
`timescale 1ns/100ps
module isr_status_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic meas_busy,
  input wire logic link_serial,
  input wire logic link_usb,
  input wire logic local_mode,
  input wire logic srq,
  input wire logic usb_intr_req,
  input wire isr_pkg::isr_oq_type oq_out,
  input wire logic trace_show,
  input wire isr_pkg::isr_err_type trace_err,
  input wire logic meters_blank
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Outputs are registered, so levels must hold over two edges
  sequence s_serial_held;
    link_serial ##1 link_serial;
  endsequence
  sequence s_local_held;
    local_mode ##1 local_mode;
  endsequence
  a_zero_wait: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or answered an error");
  a_serial_no_srq: assert property (s_serial_held |-> !srq)
    else $error("service request raised on serial link");
  a_usb_follows: assert property (
    $past(link_usb) && !$past(link_serial) |-> usb_intr_req == srq)
    else $error("usb interrupt request differs from request");
  a_meters_tied: assert property (meters_blank == trace_show)
    else $error("meter blanking differs from trace display");
  a_trace_blank: assert property (!trace_show |-> trace_err == '0)
    else $error("trace entry shown while display off");
  a_local_hides: assert property (s_local_held |-> !trace_show)
    else $error("trace display active in local mode");
  a_oq_waits: assert property ($rose(oq_out.valid) |-> !$past(meas_busy))
    else $error("query answer queued while work pending");
  a_oq_value: assert property (oq_out.valid |-> oq_out.value == 8'h01)
    else $error("query answer value is not one");
endmodule // isr_status_props
bind isr_status isr_status_props u_props (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .meas_busy(meas_busy),
  .link_serial(link_serial), .link_usb(link_usb), .local_mode(local_mode),
  .srq(srq), .usb_intr_req(usb_intr_req), .oq_out(oq_out),
  .trace_show(trace_show), .trace_err(trace_err),
  .meters_blank(meters_blank));

/* File: verif/isr_meas_model.sv */
// Measurement engine stand-in: busy for a set number of cycles
`timescale 1ns/100ps
module isr_meas_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic [7:0] len,
  output logic meas_busy
);
  logic [7:0] left_q;
  // A new start reloads the count, so runs may overlap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) left_q <= 8'h00;
    else if (start) left_q <= len;
    else if (left_q != 8'h00) left_q <= left_q - 8'h01;
  end
  assign meas_busy = (left_q != 8'h00); // Pending work
endmodule // isr_meas_model

/* File: verif/tb.sv */
// Testbench: bus-driven checks of the status unit
`timescale 1ns/100ps
module tb;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, srq, usb_intr_req, trace_show, meters_blank;
  logic meas_busy, start = 1'h0, err_push = 1'h0;
  logic integ_active = 1'h0, integ_ovf = 1'h0;
  logic link_serial = 1'h0, link_usb = 1'h0, local_mode = 1'h0;
  logic pm_keep_masks = 1'h1;
  logic [7:0] len = 8'h00;
  isr_pkg::isr_err_type err_in = 24'h0;
  isr_pkg::isr_err_type trace_err;
  isr_pkg::isr_oq_type oq_out;
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;
  // Clock at 50 MHz
  always #10 hclk = ~hclk;
  isr_meas_model u_meas (.hclk(hclk), .hresetn(hresetn), .start(start),
    .len(len), .meas_busy(meas_busy));
  // Backed-up masks: event enable 1, request enable 32
  isr_status dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .meas_busy(meas_busy),
    .integ_active(integ_active), .integ_ovf(integ_ovf),
    .err_push(err_push), .err_in(err_in), .link_serial(link_serial),
    .link_usb(link_usb), .local_mode(local_mode),
    .pm_keep_masks(pm_keep_masks), .pm_ese(8'h01), .pm_sre(8'h20),
    .srq(srq), .usb_intr_req(usb_intr_req), .oq_out(oq_out),
    .trace_show(trace_show), .trace_err(trace_err),
    .meters_blank(meters_blank));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One single transfer; waits on hready, never on a cycle count
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    rd = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(rd, e);
  endtask
  task run(input logic [7:0] n);
    len <= n;
    start <= 1'h1;
    @(posedge hclk);
    start <= 1'h0;
  endtask
  task t_reset;
    chk(32'(srq), 32'h0);
    rdc(isr_pkg::ESR_OFS, 32'h80);
    rdc(isr_pkg::ESE_OFS, 32'h01);
    rdc(isr_pkg::SRE_OFS, 32'h20);
    rdc(isr_pkg::CTRL_OFS, 32'h3);
    rdc(isr_pkg::OPER_PTR_OFS, 32'h7fff);
    rdc(8'h1c, 32'h0);
    chk(32'(oq_out.valid), 32'h0);
    $display("t_reset done");
  endtask
  task t_opc;
    run(8'h08);
    wr(isr_pkg::CMD_OFS, 32'h08);
    rdc(isr_pkg::ESR_OFS, 32'h0);
    repeat (10) @(posedge hclk);
    chk(32'(srq), 32'h1);
    rdc(isr_pkg::STB_OFS, 32'h60);
    link_serial <= 1'h1;
    repeat (2) @(posedge hclk);
    chk(32'(srq), 32'h0);
    link_serial <= 1'h0;
    link_usb <= 1'h1;
    repeat (2) @(posedge hclk);
    chk(32'(usb_intr_req), 32'h1);
    rdc(isr_pkg::ESR_OFS, 32'h01);
    repeat (2) @(posedge hclk);
    chk(32'(srq), 32'h0);
    link_usb <= 1'h0;
    $display("t_opc done");
  endtask
  task t_query;
    run(8'h06);
    wr(isr_pkg::CMD_OFS, 32'h10);
    chk(32'(oq_out.valid), 32'h0);
    repeat (8) @(posedge hclk);
    chk(32'(oq_out), 32'h101);
    rdc(isr_pkg::OPC_OFS, 32'h101);
    // Reset command and device clear abandon a waiting query
    for (int i = 1; i < 3; i++) begin
      run(8'h06);
      wr(isr_pkg::CMD_OFS, 32'h10);
      wr(isr_pkg::CMD_OFS, 32'h1 << i);
      repeat (10) @(posedge hclk);
      chk(32'(oq_out.valid), 32'h0);
    end
    $display("t_query done");
  endtask
  task t_cond;
    integ_active <= 1'h1;
    integ_ovf <= 1'h1;
    @(posedge hclk);
    rdc(isr_pkg::OPER_COND_OFS, 32'h08);
    rdc(isr_pkg::QUES_COND_OFS, 32'h01);
    rdc(isr_pkg::OPER_EVT_OFS, 32'h08);
    rdc(isr_pkg::OPER_EVT_OFS, 32'h0);
    wr(isr_pkg::OPER_COND_OFS, 32'h0);
    rdc(isr_pkg::OPER_COND_OFS, 32'h08);
    wr(isr_pkg::QUES_EN_OFS, 32'h5a);
    rdc(isr_pkg::QUES_EN_OFS, 32'h5a);
    integ_active <= 1'h0;
    integ_ovf <= 1'h0;
    $display("t_cond done");
  endtask
  task t_queue;
    // One push beyond capacity must be dropped
    for (int i = 0; i < 256; i++) begin
      err_in <= {16'(i + 1), 8'(i)};
      err_push <= 1'h1;
      @(posedge hclk);
    end
    err_push <= 1'h0;
    rdc(isr_pkg::ERR_CNT_OFS, 32'hff);
    chk(32'(trace_show), 32'h1);
    chk(32'(trace_err), 32'h100);
    local_mode <= 1'h1;
    repeat (2) @(posedge hclk);
    chk(32'(trace_show), 32'h0);
    local_mode <= 1'h0;
    wr(isr_pkg::CTRL_OFS, 32'h1);
    repeat (2) @(posedge hclk);
    chk(32'(trace_show), 32'h0);
    wr(isr_pkg::CTRL_OFS, 32'h3);
    rdc(isr_pkg::ERR_POP_OFS, 32'h100);
    rdc(isr_pkg::ERR_POP_OFS, 32'h201);
    wr(isr_pkg::CMD_OFS, 32'h01);
    rdc(isr_pkg::ERR_CNT_OFS, 32'h0);
    chk(32'(trace_show), 32'h0);
    rdc(isr_pkg::ERR_POP_OFS, 32'h0);
    err_in <= 24'h00ff07;
    err_push <= 1'h1;
    @(posedge hclk);
    err_push <= 1'h0;
    rdc(isr_pkg::ERR_POP_OFS, 32'hff07);
    rdc(isr_pkg::ERR_CNT_OFS, 32'h0);
    $display("t_queue done");
  endtask
  // Power cycle with masks not kept: masks and queue start empty
  task t_power;
    pm_keep_masks <= 1'h0;
    err_in <= 24'h000102;
    err_push <= 1'h1;
    @(posedge hclk);
    err_push <= 1'h0;
    rdc(isr_pkg::ERR_CNT_OFS, 32'h1);
    hresetn <= 1'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (2) @(posedge hclk);
    rdc(isr_pkg::ESE_OFS, 32'h0);
    rdc(isr_pkg::SRE_OFS, 32'h0);
    rdc(isr_pkg::ERR_CNT_OFS, 32'h0);
    rdc(isr_pkg::ESR_OFS, 32'h80);
    $display("t_power done");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      wrap_up();
    end
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (2) @(posedge hclk);
    t_reset();
    t_opc();
    t_query();
    t_cond();
    t_queue();
    t_power();
    wrap_up();
  end
endmodule // tb
